// ===== emb_consts.svh
// Purpose: Offsets, field positions, reset values and counts of the bus control block
// Assumes: 32-bit APB with one aligned word per register
// Notes: Definitions only
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH

// Register byte offsets
`define EMB_OFF_CTRL_A 8'h00
`define EMB_OFF_CTRL_B 8'h04

// Control A fields
`define EMB_A_ENABLE_BIT 7
`define EMB_A_LIMIT_HI 6
`define EMB_A_LIMIT_LO 4
`define EMB_A_UPPER_HI 3
`define EMB_A_UPPER_LO 2
`define EMB_A_LOWER_HI 1
`define EMB_A_LOWER_LO 0

// Control B fields
`define EMB_B_KEEPER_BIT 7
`define EMB_B_MASK_HI 2
`define EMB_B_MASK_LO 0
`define EMB_B_WRITABLE 8'h87

// Reset values
`define EMB_CTRL_A_RESET 8'h00
`define EMB_CTRL_B_RESET 8'h00

// Sector granule is 0x2000 bytes, so the limit sits at bit 13 and above
`define EMB_SECTOR_SHIFT 13

// Pin indices of the control group
`define EMB_CTL_ALE 2
`define EMB_CTL_RD 1
`define EMB_CTL_WR 0

// Wait code with an idle cycle after the access
`define EMB_WS_GAP 2'h3
// Strobe cycles with no wait state
`define EMB_STROBE_BASE 2'h1

`endif

// ===== emb_pkg.sv
// Purpose: Types shared by the bus control block
// Assumes: Constants come from emb_consts.svh
// Notes: Types only
package emb_pkg;

    // Access sequencer states, one-hot
    typedef enum logic [5:0] {
        S_IDLE   = 6'b000001,
        S_ALE    = 6'b000010,
        S_LATCH  = 6'b000100,
        S_STROBE = 6'b001000,
        S_HOLD   = 6'b010000,
        S_GAP    = 6'b100000
    } emb_state_t;

    // Two-bit wait-state code
    typedef logic [1:0] emb_ws_t;

endpackage

// ===== emb_sect_if.sv
// Purpose: Carries an access address and sector settings to the decoder and its answer back
// Assumes: Purely combinational exchange
// Notes: ctl drives the request, dec drives the answer
`timescale 1ns/100ps
interface emb_sect_if;
    logic [15:0] addr;
    logic [2:0] limit;
    emb_pkg::emb_ws_t upper_ws;
    emb_pkg::emb_ws_t lower_ws;
    logic is_ext;
    logic is_upper;
    emb_pkg::emb_ws_t ws;

    modport ctl (output addr, output limit, output upper_ws, output lower_ws,
                 input is_ext, input is_upper, input ws);
    modport dec (input addr, input limit, input upper_ws, input lower_ws,
                 output is_ext, output is_upper, output ws);
endinterface

// ===== emb_sector.sv
// Purpose: Internal/external split and sector wait-state selection for one address
// Assumes: Internal memory spans 0 up to INTERNAL_SRAM_END
// Notes: Combinational only
`timescale 1ns/100ps
`include "emb_consts.svh"
module emb_sector #(
    parameter logic [15:0] INTERNAL_SRAM_END = 16'h10ff
) (
    emb_sect_if.dec sif
);
    logic [15:0] boundary;

    // Boundary is the limit times 0x2000
    assign boundary = {sif.limit, 13'h0};

    assign sif.is_ext = (sif.addr > INTERNAL_SRAM_END);

    // zero limit means one upper sector
    assign sif.is_upper = (sif.limit == 3'h0) || (sif.addr >= boundary);

    assign sif.ws = sif.is_upper ? sif.upper_ws : sif.lower_ws;
endmodule

// ===== emb_ctrl.sv
// Purpose: External memory bus control with APB registers, pin takeover and wait states
// Assumes: Core access port and all pins synchronous to MCLK; pins settle within a cycle
// Notes: All top outputs are registered; one external access in flight at a time
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
`include "emb_consts.svh"
module emb_ctrl #(
    parameter logic [15:0] INTERNAL_SRAM_END = 16'h10ff
) (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic [31:0] PRDATA,
    input wire logic CORE_REQ,
    input wire logic CORE_WE,
    input wire logic [15:0] CORE_ADDR,
    input wire logic [7:0] CORE_WDATA,
    output logic CORE_BUSY,
    output logic CORE_DONE,
    output logic CORE_EXT,
    output logic [7:0] CORE_RDATA,
    input wire logic [7:0] PORTA_VAL,
    input wire logic [7:0] PORTA_DIR,
    input wire logic [7:0] PORTC_VAL,
    input wire logic [7:0] PORTC_DIR,
    input wire logic [2:0] PORTG_VAL,
    input wire logic [2:0] PORTG_DIR,
    input wire logic [7:0] AD_I,
    output logic [7:0] AD_O,
    output logic [7:0] AD_OE,
    output logic [7:0] PC_O,
    output logic [7:0] PC_OE,
    output logic [2:0] CTL_O,
    output logic [2:0] CTL_OE,
    output logic KEEP_EN,
    output logic [7:0] KEEP_VAL
);

    // Pins still carrying address for a given mask value
    function automatic logic [7:0] hi_pins(input logic [2:0] m);
        logic [7:0] r;
        r = 8'hff >> m;
        if (m == 3'h7) begin
            r = 8'h00;
        end
        return r;
    endfunction

    // Extra strobe cycles for a wait code
    function automatic logic [1:0] strobe_extra(input emb_pkg::emb_ws_t c);
        logic [1:0] r;
        r = c;
        if (c == `EMB_WS_GAP) begin
            r = 2'h2;
        end
        return r;
    endfunction

    // Control registers
    logic [7:0] ctrl_a_reg;
    logic [7:0] ctrl_b_reg;
    logic en;
    logic [2:0] mask;
    logic [7:0] ctrl_b_view;

    // APB signals
    logic sel_a;
    logic sel_b;
    logic mapped;
    logic setup;
    logic wr_take;
    logic [7:0] rd_byte;

    // Sequencer
    emb_pkg::emb_state_t state_reg;
    emb_pkg::emb_state_t state_next;
    logic [15:0] addr_reg;
    logic [15:0] addr_next;
    logic [7:0] wdata_reg;
    logic [7:0] wdata_next;
    logic we_reg;
    logic we_next;
    logic ext_reg;
    logic ext_next;
    emb_pkg::emb_ws_t ws_reg;
    emb_pkg::emb_ws_t ws_next;
    logic [1:0] cnt_reg;
    logic [1:0] cnt_next;
    logic accept;
    logic done_next;
    logic capture;

    // Pin next values
    logic [7:0] ad_o_next;
    logic [7:0] ad_oe_next;
    logic [7:0] pc_o_next;
    logic [7:0] pc_oe_next;
    logic [2:0] ctl_o_next;
    logic [2:0] ctl_oe_next;
    logic [7:0] pc_sel;
    logic [7:0] pad_level;

    emb_sect_if sif ();

    // Sector decode of the requested address
    emb_sector #(
        .INTERNAL_SRAM_END(INTERNAL_SRAM_END)
    ) u_sector (
        .sif(sif)
    );

    assign sif.addr = CORE_ADDR;
    assign sif.limit = ctrl_a_reg[`EMB_A_LIMIT_HI:`EMB_A_LIMIT_LO];
    assign sif.upper_ws = ctrl_a_reg[`EMB_A_UPPER_HI:`EMB_A_UPPER_LO];
    assign sif.lower_ws = ctrl_a_reg[`EMB_A_LOWER_HI:`EMB_A_LOWER_LO];

    assign en = ctrl_a_reg[`EMB_A_ENABLE_BIT];
    assign mask = ctrl_b_reg[`EMB_B_MASK_HI:`EMB_B_MASK_LO];

    // reserved bits never stored, read zero
    assign ctrl_b_view = ctrl_b_reg & `EMB_B_WRITABLE;

    // APB decode; one wait-free access phase, unmapped answers with error
    assign sel_a = (PADDR == `EMB_OFF_CTRL_A);
    assign sel_b = (PADDR == `EMB_OFF_CTRL_B);
    assign mapped = sel_a || sel_b;
    assign setup = PSEL && !PENABLE;
    assign wr_take = PSEL && PENABLE && PREADY && PWRITE && mapped;
    assign rd_byte = sel_a ? ctrl_a_reg : (sel_b ? ctrl_b_view : 8'h00);

    // APB answer registers
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end else if (CE) begin
            PREADY <= setup;
            PSLVERR <= setup && !mapped;
            PRDATA <= {24'h000000, (setup && !PWRITE) ? rd_byte : 8'h00};
        end
    end

    // Control register writes take effect at the completing edge
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_a_reg <= `EMB_CTRL_A_RESET;
            ctrl_b_reg <= `EMB_CTRL_B_RESET;
        end else if (CE && wr_take) begin
            if (sel_a) begin
                ctrl_a_reg <= PWDATA[7:0];
            end else begin
                ctrl_b_reg <= PWDATA[7:0] & `EMB_B_WRITABLE;
            end
        end
    end

    // New requests only in idle; busy ones are ignored
    assign accept = CORE_REQ && (state_reg == emb_pkg::S_IDLE);

    // Sequencer next state
    always_comb begin
        state_next = state_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        we_next = we_reg;
        ext_next = ext_reg;
        ws_next = ws_reg;
        cnt_next = cnt_reg;
        done_next = 1'b0;
        capture = 1'b0;
        case (state_reg)
            emb_pkg::S_IDLE: begin
                if (accept) begin
                    addr_next = CORE_ADDR;
                    wdata_next = CORE_WDATA;
                    we_next = CORE_WE;
                    ext_next = sif.is_ext;
                    ws_next = sif.ws;
                    if (en) begin
                        // internal ones still pulse the latch strobe
                        state_next = emb_pkg::S_ALE;
                    end else begin
                        // disabled, nothing goes out or aliases
                        done_next = 1'b1;
                    end
                end
            end
            emb_pkg::S_ALE: begin
                state_next = emb_pkg::S_LATCH;
            end
            emb_pkg::S_LATCH: begin
                if (ext_reg) begin
                    // base strobe plus extra wait cycles
                    cnt_next = strobe_extra(ws_reg);
                    state_next = emb_pkg::S_STROBE;
                end else begin
                    state_next = emb_pkg::S_IDLE;
                    done_next = 1'b1;
                end
            end
            emb_pkg::S_STROBE: begin
                if (cnt_reg == 2'h0) begin
                    capture = !we_reg;
                    state_next = emb_pkg::S_HOLD;
                end else begin
                    cnt_next = cnt_reg - 2'h1;
                end
            end
            emb_pkg::S_HOLD: begin
                // idle cycle before the next address
                if (ws_reg == `EMB_WS_GAP) begin
                    state_next = emb_pkg::S_GAP;
                end else begin
                    state_next = emb_pkg::S_IDLE;
                    done_next = 1'b1;
                end
            end
            emb_pkg::S_GAP: begin
                state_next = emb_pkg::S_IDLE;
                done_next = 1'b1;
            end
            default: begin
                state_next = emb_pkg::S_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            state_reg <= emb_pkg::S_IDLE;
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
            we_reg <= 1'b0;
            ext_reg <= 1'b0;
            ws_reg <= 2'h0;
            cnt_reg <= 2'h0;
        end else if (CE) begin
            state_reg <= state_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            we_reg <= we_next;
            ext_reg <= ext_next;
            ws_reg <= ws_next;
            cnt_reg <= cnt_next;
        end
    end

    // Core answer; unserved reads return zero
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            CORE_BUSY <= 1'b0;
            CORE_DONE <= 1'b0;
            CORE_EXT <= 1'b0;
            CORE_RDATA <= 8'h00;
        end else if (CE) begin
            CORE_BUSY <= (state_next != emb_pkg::S_IDLE);
            CORE_DONE <= done_next;
            if (done_next) begin
                CORE_EXT <= ext_next && en;
            end
            if (accept) begin
                CORE_RDATA <= 8'h00;
            end else if (capture) begin
                CORE_RDATA <= AD_I;
            end
        end
    end

    // Low byte lines: address, then write data, else float
    always_comb begin
        ad_o_next = PORTA_VAL;
        ad_oe_next = PORTA_DIR;
        if (en) begin
            ad_o_next = addr_next[7:0];
            ad_oe_next = 8'h00;
            case (state_next)
                // address held through the latch fall
                emb_pkg::S_ALE, emb_pkg::S_LATCH: begin
                    ad_oe_next = 8'hff;
                end
                emb_pkg::S_STROBE, emb_pkg::S_HOLD: begin
                    ad_o_next = wdata_next;
                    ad_oe_next = {8{we_next}};
                end
                default: begin
                    ad_oe_next = 8'h00;
                end
            endcase
        end
    end

    // Control pins: latch strobe high only in address cycle, strobes low active
    always_comb begin
        ctl_o_next = PORTG_VAL;
        ctl_oe_next = PORTG_DIR;
        if (en) begin
            ctl_oe_next = 3'h7;
            ctl_o_next[`EMB_CTL_ALE] = (state_next == emb_pkg::S_ALE);
            // strobes move only for external accesses
            ctl_o_next[`EMB_CTL_RD] = !((state_next == emb_pkg::S_STROBE) && !we_next);
            ctl_o_next[`EMB_CTL_WR] = !((state_next == emb_pkg::S_STROBE) && we_next);
        end
    end

    // zero mask keeps all pins on address
    // mask trims high pins from the top
    assign pc_sel = en ? hi_pins(mask) : 8'h00;

    // released pins fall back to port settings
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pc
            assign pc_o_next[gi] = pc_sel[gi] ? addr_next[8 + gi] : PORTC_VAL[gi];
            assign pc_oe_next[gi] = pc_sel[gi] ? 1'b1 : PORTC_DIR[gi];
        end
    endgenerate

    // Keeper watches what the pad shows
    assign pad_level = (AD_O & AD_OE) | (AD_I & ~AD_OE);

    // enabled pins driven by the interface
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            AD_O <= 8'h00;
            AD_OE <= 8'h00;
            PC_O <= 8'h00;
            PC_OE <= 8'h00;
            CTL_O <= 3'h0;
            CTL_OE <= 3'h0;
        end else if (CE) begin
            AD_O <= ad_o_next;
            AD_OE <= ad_oe_next;
            PC_O <= pc_o_next;
            PC_OE <= pc_oe_next;
            CTL_O <= ctl_o_next;
            CTL_OE <= ctl_oe_next;
        end
    end

    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            KEEP_EN <= 1'b0;
            KEEP_VAL <= 8'h00;
        end else if (CE) begin
            KEEP_EN <= ctrl_b_reg[`EMB_B_KEEPER_BIT];
            KEEP_VAL <= pad_level;
        end
    end

    // reachable space follows from INTERNAL_SRAM_END and the mask
    // ALE low after the address cycle relies on an external transparent latch
endmodule

// ===== emb_ctrl_assertions.sv
// Purpose: Port-level checks of the external memory bus control block
// Assumes: Clock enable held high; shadows follow completed APB writes
// Notes: Bound into emb_ctrl below
`timescale 1ns/100ps
module emb_ctrl_assertions #(
    parameter logic [15:0] INTERNAL_SRAM_END = 16'h10ff
) (
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic PREADY,
    input wire logic CORE_REQ,
    input wire logic CORE_BUSY,
    input wire logic [15:0] CORE_ADDR,
    input wire logic CORE_DONE,
    input wire logic CORE_EXT,
    input wire logic [7:0] PORTC_VAL,
    input wire logic [7:0] AD_O,
    input wire logic [7:0] PC_O,
    input wire logic [2:0] CTL_O,
    input wire logic KEEP_EN
);
    logic [7:0] a_reg, b_reg, ah_reg;
    logic [3:0] lat_reg, sl_reg;
    logic [1:0] ws_reg;
    logic ext_reg, dis_reg;
    // Sector and mask decode of the request being taken
    wire logic wr = PSEL && PENABLE && PREADY && PWRITE;
    wire logic take = CORE_REQ && !CORE_BUSY;
    wire logic up = a_reg[6:4] == 3'h0 || CORE_ADDR[15:13] >= a_reg[6:4];
    wire logic [1:0] ws = up ? a_reg[3:2] : a_reg[1:0];
    wire logic [7:0] keep = b_reg[2:0] == 3'h7 ? 8'h00 : 8'hff >> b_reg[2:0];
    // Control shadows
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            a_reg <= 8'h00;
            b_reg <= 8'h00;
        end else if (wr && PADDR == 8'h00) begin
            a_reg <= PWDATA[7:0];
        end else if (wr && PADDR == 8'h04) begin
            b_reg <= PWDATA[7:0] & 8'h87;
        end
    end
    // Access figures; counters wrap, only read at done or strobe end
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            {ext_reg, dis_reg, ws_reg, ah_reg, lat_reg, sl_reg} <= '0;
        end else begin
            dis_reg <= !a_reg[7];
            lat_reg <= take ? 4'h1 : lat_reg + 4'h1;
            sl_reg <= &CTL_O[1:0] ? 4'h0 : sl_reg + 4'h1;
            if (take) begin
                ext_reg <= a_reg[7] && CORE_ADDR > INTERNAL_SRAM_END;
                ws_reg <= ws;
                ah_reg <= CORE_ADDR[15:8];
            end
        end
    end
    default clocking dc @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    property p_keep_alone;
        wr && PADDR == 8'h04 |=> ##1 KEEP_EN == b_reg[7];
    endproperty
    a_keep_alone: assert property (p_keep_alone) else $error("keeper bit not followed");
    property p_port_mode;
        dis_reg |-> PC_O == $past(PORTC_VAL);
    endproperty
    a_port_mode: assert property (p_port_mode) else $error("port value not on pins");
    property p_int_quiet;
        take && CORE_ADDR <= INTERNAL_SRAM_END |-> ##1 (&CTL_O[1:0]) [*3];
    endproperty
    a_int_quiet: assert property (p_int_quiet) else $error("strobe on internal access");
    property p_int_local;
        take && CORE_ADDR <= INTERNAL_SRAM_END |-> ##[1:4] (CORE_DONE && !CORE_EXT);
    endproperty
    a_int_local: assert property (p_int_local) else $error("internal access went out");
    property p_ale_addr;
        ext_reg && CORE_BUSY && $fell(CTL_O[2]) |-> $stable(AD_O);
    endproperty
    a_ale_addr: assert property (p_ale_addr) else $error("address moved at latch fall");
    property p_high_addr;
        ext_reg && CORE_BUSY && CTL_O[2] |->
            PC_O == ((ah_reg & keep) | ($past(PORTC_VAL) & ~keep));
    endproperty
    a_high_addr: assert property (p_high_addr) else $error("high address pins wrong");
    property p_latency;
        CORE_DONE && ext_reg |-> lat_reg == 4'h5 + {2'h0, ws_reg};
    endproperty
    a_latency: assert property (p_latency) else $error("access length wrong");
    property p_strobe_len;
        ext_reg && $rose(&CTL_O[1:0]) |->
            sl_reg == (ws_reg == 2'h3 ? 4'h3 : {2'h0, ws_reg} + 4'h1);
    endproperty
    a_strobe_len: assert property (p_strobe_len) else $error("strobe length wrong");
endmodule

bind emb_ctrl emb_ctrl_assertions #(.INTERNAL_SRAM_END(INTERNAL_SRAM_END)) emb_ctrl_assertions_i (
    .MCLK(MCLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .CORE_REQ(CORE_REQ),
    .CORE_BUSY(CORE_BUSY), .CORE_ADDR(CORE_ADDR), .CORE_DONE(CORE_DONE), .CORE_EXT(CORE_EXT),
    .PORTC_VAL(PORTC_VAL), .AD_O(AD_O), .PC_O(PC_O), .CTL_O(CTL_O), .KEEP_EN(KEEP_EN));

// ===== emb_sram_model.sv
// Purpose: Byte memory behind a transparent address latch
// Assumes: Strobes active low, latch gate active high
// Notes: An undriven pad flips each cycle unless the keeper holds it
`timescale 1ns/100ps
module emb_sram_model (
    input wire logic clk,
    input wire logic [7:0] ad_o,
    input wire logic [7:0] ad_oe,
    input wire logic [7:0] pc_o,
    input wire logic [2:0] ctl_o,
    input wire logic keep_en,
    input wire logic [7:0] keep_val,
    output logic [7:0] ad_i
);
    logic [7:0] mem [0:65535];
    logic [7:0] lat, last, far;
    always_latch if (ctl_o[2]) lat <= ad_i;
    // Write data taken from the pad
    always @(posedge clk) if (!ctl_o[0]) mem[{pc_o, lat}] <= ad_i;
    // keeper level, else a flipping float
    assign far = !ctl_o[1] ? mem[{pc_o, lat}] : keep_en ? keep_val : ~last;
    assign ad_i = (ad_oe & ad_o) | (~ad_oe & far);
    always @(posedge clk) last <= ad_i;
endmodule

// ===== tb_emb_ctrl.sv
// Purpose: Self-checking bench for the external memory bus control block
// Assumes: Registers at 0x00 and 0x04, internal memory ends at 0x10ff
// Notes: Clock enable dropped once, only while idle and disabled
`timescale 1ns/100ps
module tb_emb_ctrl;
    logic mclk, resetn, psel, penable, pwrite, pready, pslverr, serr;
    logic req, we, busy, done, ext, keep_en, ce;
    logic [7:0] paddr, wdata, rdata, pa_val, pa_dir, pc_val, pc_dir, ad_i, ad_o, ad_oe;
    logic [7:0] pc_o, pc_oe, keep_val;
    logic [31:0] pwdata, prdata, q;
    logic [15:0] addr;
    logic [2:0] pg_val, pg_dir, ctl_o, ctl_oe;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    emb_ctrl #(.INTERNAL_SRAM_END(16'h10ff)) emb_ctrl_i (
        .MCLK(mclk), .RESETN(resetn), .CE(ce), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PSLVERR(pslverr),
        .PRDATA(prdata), .CORE_REQ(req), .CORE_WE(we), .CORE_ADDR(addr), .CORE_WDATA(wdata),
        .CORE_BUSY(busy), .CORE_DONE(done), .CORE_EXT(ext), .CORE_RDATA(rdata),
        .PORTA_VAL(pa_val), .PORTA_DIR(pa_dir), .PORTC_VAL(pc_val), .PORTC_DIR(pc_dir),
        .PORTG_VAL(pg_val), .PORTG_DIR(pg_dir), .AD_I(ad_i), .AD_O(ad_o), .AD_OE(ad_oe),
        .PC_O(pc_o), .PC_OE(pc_oe), .CTL_O(ctl_o), .CTL_OE(ctl_oe), .KEEP_EN(keep_en),
        .KEEP_VAL(keep_val));
    emb_sram_model emb_sram_model_i (.clk(mclk), .ad_o(ad_o), .ad_oe(ad_oe), .pc_o(pc_o),
        .ctl_o(ctl_o), .keep_en(keep_en), .keep_val(keep_val), .ad_i(ad_i));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task print_verdict();
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] v);
        checks++;
        if (v !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", s, e, v);
        end
    endtask
    // Setup, then access until ready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One core request; n counts edges from take to done
    task core(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= 1'b1;
        we <= w;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        req <= 1'b0;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (done !== 1'b1);
    endtask
    task port_chk();
        repeat (2) @(posedge mclk);
        chk("ad_o", pa_val, ad_o);
        chk("ad_oe", pa_dir, ad_oe);
        chk("ctl_o", pg_val, ctl_o);
        chk("ctl_oe", pg_dir, ctl_oe);
        chk("pc_o", pc_val, pc_o);
        chk("pc_oe", pc_dir, pc_oe);
    endtask
    // Hang guard
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        {resetn, psel, penable, pwrite, req, we, paddr, pwdata, addr, wdata} = '0;
        ce = 1'b1;
        pa_val = 8'h5a;
        pa_dir = 8'hff;
        pc_val = 8'h00;
        pc_dir = 8'hff;
        pg_val = 3'h3;
        pg_dir = 3'h7;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        // Unmapped write is dropped; reset values read back
        apb(1'b1, 8'h08, 32'hff);
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("reset value", 32'h0, q);
            chk("slave error", 32'(i == 2), 32'(serr));
        end
        apb(1'b1, 8'h04, 32'hff);
        apb(1'b0, 8'h04, 32'h0);
        chk("ctrl_b", 32'h87, q);
        chk("keep_en", 1'b1, keep_en);
        port_chk();
        // Floating pads held by the keeper
        pa_dir <= 8'h00;
        pg_dir <= 3'h0;
        repeat (4) @(posedge mclk);
        chk("keep_val", 8'h5a, keep_val);
        core(1'b0, 16'h2000, 8'h00);
        chk("off ext", 1'b0, ext);
        chk("off data", 8'h00, rdata);
        // Each wait code in both sectors, pins taken despite input direction
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, 8'h00, 32'(8'h90 | (c << 2) | (3 - c)));
            core(1'b1, 16'(16'h2000 + c), 8'(8'ha0 + c));
            chk("upper wait", 5 + c, n);
            core(1'b1, 16'(16'h1ffc + c), 8'(8'hb0 + c));
            chk("lower wait", 8 - c, n);
            core(1'b0, 16'(16'h2000 + c), 8'h00);
            chk("upper data", 8'ha0 + c, rdata);
            chk("ext", 1'b1, ext);
            chk("ctl_oe taken", 3'h7, ctl_oe);
            core(1'b0, 16'(16'h1ffc + c), 8'h00);
            chk("lower data", 8'hb0 + c, rdata);
        end
        apb(1'b1, 8'h00, 32'h88);
        core(1'b1, 16'h1100, 8'h11);
        chk("one sector", 7, n);
        core(1'b0, 16'h10ff, 8'h00);
        chk("internal", 1'b0, ext);
        core(1'b0, 16'h1100, 8'h00);
        chk("first ext", 8'h11, rdata);
        // Every mask, then the hidden low block reached
        for (int m = 7; m >= 0; m--) begin
            apb(1'b1, 8'h04, 32'(m));
            core(1'b1, 16'hfe01, 8'(m));
            chk("mask addr", 8'(m),
                emb_sram_model_i.mem[{8'hfe & (m == 7 ? 8'h00 : 8'hff >> m), 8'h01}]);
        end
        apb(1'b1, 8'h04, 32'h3);
        core(1'b1, 16'h2001, 8'haa);
        apb(1'b1, 8'h04, 32'h0);
        core(1'b1, 16'h2001, 8'h55);
        chk("masked", 8'haa, emb_sram_model_i.mem[16'h0001]);
        chk("unmasked", 8'h55, emb_sram_model_i.mem[16'h2001]);
        chk("keep off", 1'b0, keep_en);
        apb(1'b1, 8'h00, 32'h0);
        pa_val <= 8'hc3;
        pa_dir <= 8'hff;
        port_chk();
        // Clock enable low freezes the pins
        ce <= 1'b0;
        pa_val <= 8'h3c;
        repeat (3) @(posedge mclk);
        chk("frozen ad_o", 8'hc3, ad_o);
        ce <= 1'b1;
        port_chk();
        print_verdict();
    end
endmodule
